// file: verification/mmpc_host_model.sv
// two-wire bus host: scl stands high outside frames, sda only ever pulled low
`timescale 1ns/1ns
module mmpc_host_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // free clocks with sda released; the link side needs edges to leave its reset
    task automatic bus_clocks(input int n);
        repeat (n) begin
            #15 scl = 1'b0;
            #15 scl = 1'b1;
        end
    endtask : bus_clocks
    task automatic start_cond();
        sda_low = 1'b0;
        #8 scl = 1'b1;
        #8 sda_low = 1'b1;
        #8 scl = 1'b0;
        #6;
    endtask : start_cond
    task automatic stop_cond();
        sda_low = 1'b1;
        #8 scl = 1'b1;
        #8 sda_low = 1'b0;
        #14;
    endtask : stop_cond
    // data changes only while scl is low, sampled mid-high
    task automatic clk_bit(input logic v, output logic s);
        sda_low = !v;
        #8 scl = 1'b1;
        #9 s = sda;
        #6 scl = 1'b0;
        #7;
    endtask : clk_bit
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask : put_byte
    task automatic get_byte(output logic [7:0] b, input logic more);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(!more, s);
    endtask : get_byte
endmodule : mmpc_host_model

// file: verification/mmpc_pin_ctrl_asserts.sv
// port assertions for the management pin control block
`timescale 1ns/1ns
module mmpc_pin_ctrl_asserts #(
    parameter int RESET_MIN_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic fault_event,
    input wire logic module_present_n_out,
    input wire logic module_present_n_oe,
    input wire logic interrupt_out_n_out,
    input wire logic interrupt_out_n_oe,
    input wire logic power_limit,
    input wire logic restore_defaults,
    input wire logic data_not_ready
);
    logic pin_d_r;
    logic scl_d_r;
    logic [15:0] run_len_r;
    logic [7:0] quiet_r;
    // low run is held after release, since restore lags the pin by the synchroniser
    always_ff @(posedge ref_clk) begin
        pin_d_r <= module_reset_n;
        scl_d_r <= scl;
        if (!rstn) begin
            run_len_r <= 16'h0000;
        end else if (!module_reset_n) begin
            run_len_r <= pin_d_r ? 16'h0001 : run_len_r + 16'h0001;
        end
        quiet_r <= (!rstn || scl != scl_d_r) ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hFF};
    end
    property p_sel_quiet;
        @(negedge scl) disable iff (!rstn) module_select_n [*5] |-> !sda_oe;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("sda pulled while deselected");
    property p_long_low;
        @(posedge ref_clk) disable iff (!rstn)
            !module_reset_n && run_len_r > RESET_MIN_CYC + 5 |-> restore_defaults;
    endproperty
    a_long_low: assert property (p_long_low) else $error("long reset pin low ignored");
    property p_short_skip;
        @(posedge ref_clk) disable iff (!rstn) $rose(restore_defaults) |-> run_len_r >= RESET_MIN_CYC;
    endproperty
    a_short_skip: assert property (p_short_skip) else $error("short pulse restored");
    property p_ready_int;
        @(posedge ref_clk) disable iff (!rstn) $fell(data_not_ready) |-> ##1 interrupt_out_n_oe;
    endproperty
    a_ready_int: assert property (p_ready_int) else $error("no done interrupt");
    property p_hold_busy;
        @(posedge ref_clk) disable iff (!rstn)
            restore_defaults [*2] |-> data_not_ready && !interrupt_out_n_oe;
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("ready during restore");
    property p_fault;
        @(posedge ref_clk) disable iff (!rstn)
            fault_event && !data_not_ready && !restore_defaults |-> ##[1:2] interrupt_out_n_oe;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not flagged");
    property p_int_hold;
        @(posedge ref_clk) disable iff (!rstn)
            $fell(interrupt_out_n_oe) |-> restore_defaults || quiet_r < 8'h10;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt dropped unread");
    property p_lp;
        @(posedge ref_clk) disable iff (!rstn) low_power_request [*5] |-> power_limit;
    endproperty
    a_lp: assert property (p_lp) else $error("low power not limited");
    property p_present;
        @(posedge ref_clk) disable iff (!rstn) module_present_n_oe && !module_present_n_out;
    endproperty
    a_present: assert property (p_present) else $error("presence not grounded");
    property p_open_drain;
        @(posedge ref_clk) disable iff (!rstn) !interrupt_out_n_out && !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    c_restore: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(restore_defaults));
    c_fault: cover property (@(posedge ref_clk) disable iff (!rstn) fault_event ##1 interrupt_out_n_oe);
    c_ack: cover property (@(negedge scl) disable iff (!rstn) $rose(sda_oe));
endmodule : mmpc_pin_ctrl_asserts

bind mmpc_pin_ctrl mmpc_pin_ctrl_asserts #(.RESET_MIN_CYC(RESET_MIN_CYC)) i_chk (
    .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_request(low_power_request), .fault_event(fault_event),
    .module_present_n_out(module_present_n_out), .module_present_n_oe(module_present_n_oe),
    .interrupt_out_n_out(interrupt_out_n_out), .interrupt_out_n_oe(interrupt_out_n_oe),
    .power_limit(power_limit), .restore_defaults(restore_defaults),
    .data_not_ready(data_not_ready)
);

// file: verification/mmpc_pin_ctrl_test.sv
// self-checking bench for the management pin control block
`timescale 1ns/1ns
module mmpc_pin_ctrl_test import mmpc_pkg::*;;
    localparam logic [6:0] DEV = 7'h50;
    localparam int RST_MIN = 4;
    logic ref_clk = 1'b0;
    logic rstn, module_select_n, module_reset_n, low_power_request, fault_event;
    logic scl, host_low, sda_oe, sda_out, present_out, present_oe, int_out, int_oe;
    logic power_limit, restore_defaults, data_not_ready, ack;
    wire sda_wire = !(host_low || (sda_oe && !sda_out));
    wire present_pin = !(present_oe && !present_out);
    wire int_pin = !(int_oe && !int_out);
    int miscompares, n_compared, seed, exp_ctrl, exp_flags;
    mmpc_byte_type d, d2;
    always #5 ref_clk = !ref_clk;
    mmpc_pin_ctrl #(.DEV_ADDR(DEV), .RESET_MIN_CYC(RST_MIN), .INIT_CYC(4)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .module_select_n(module_select_n), .module_reset_n(module_reset_n),
        .low_power_request(low_power_request), .fault_event(fault_event),
        .module_present_n_out(present_out), .module_present_n_oe(present_oe),
        .interrupt_out_n_out(int_out), .interrupt_out_n_oe(int_oe), .power_limit(power_limit),
        .restore_defaults(restore_defaults), .data_not_ready(data_not_ready)
    );
    mmpc_host_model i_host (.scl(scl), .sda_low(host_low), .sda(sda_wire));
    task automatic stop_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // settle past the edge so register updates have landed
    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : look
    task automatic wait_ready();
        int k;
        k = 0;
        while (data_not_ready !== 1'b0 && k < 300) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 300) begin
            miscompares++;
            $display("[FAIL] %0t ready timeout", $time);
            stop_test();
        end
    endtask : wait_ready
    task automatic bus_write(input logic [7:0] ptr, input logic [7:0] val);
        i_host.start_cond();
        i_host.put_byte({DEV, 1'b0}, ack);
        i_host.put_byte(ptr, ack);
        i_host.put_byte(val, ack);
        chk(8'(ack), 8'h01, "write ack");
        i_host.stop_cond();
    endtask : bus_write
    task automatic bus_read(input logic [7:0] ptr, output mmpc_byte_type val, input logic more);
        i_host.start_cond();
        i_host.put_byte({DEV, 1'b0}, ack);
        i_host.put_byte(ptr, ack);
        i_host.start_cond();
        i_host.put_byte({DEV, 1'b1}, ack);
        chk(8'(ack), 8'h01, "read ack");
        i_host.get_byte(val, more);
        if (more) begin
            i_host.get_byte(d2, 1'b0);
        end
        i_host.stop_cond();
    endtask : bus_read
    task automatic chk_limit();
        look(6);
        chk(8'(power_limit), 8'(exp_ctrl[1] ? exp_ctrl[0] : low_power_request), "limit");
    endtask : chk_limit
    // status is trusted only after the done interrupt; reading flags clears them
    task automatic done_seq();
        wait_ready();
        look(2);
        chk(8'(int_pin), 8'h00, "int pin low");
        chk(8'(present_pin), 8'h00, "present");
        bus_read(8'h00, d, 1'b1);
        chk(d, 8'h08, "status ready");
        chk(d2, 8'(exp_flags), "flags");
        exp_flags = 0;
        look(8);
        chk(8'(int_pin), 8'h01, "int released");
    endtask : done_seq
    initial begin
        seed = 53200;
        miscompares = 0;
        n_compared = 0;
        rstn = 1'b0;
        module_select_n = 1'b0;
        module_reset_n = 1'b1;
        low_power_request = 1'b0;
        fault_event = 1'b0;
        exp_ctrl = 0;
        exp_flags = 1;
        // link side takes rstn on scl edges, so reset spans four scl clocks
        i_host.bus_clocks(4);
        @(posedge ref_clk);
        rstn <= 1'b1;
        i_host.bus_clocks(3);
        done_seq();
        @(posedge ref_clk);
        module_select_n <= 1'b1;
        i_host.bus_clocks(3);
        i_host.start_cond();
        i_host.put_byte({DEV, 1'b0}, ack);
        chk(8'(ack), 8'h00, "deselected ack");
        i_host.stop_cond();
        @(posedge ref_clk);
        module_select_n <= 1'b0;
        i_host.bus_clocks(3);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            low_power_request <= (i == 0) ? 1'b1 : 1'($random(seed));
            chk_limit();
        end
        @(posedge ref_clk);
        low_power_request <= 1'b0;
        bus_write(8'h02, 8'h03);
        exp_ctrl = 3;
        chk_limit();
        @(posedge ref_clk);
        module_reset_n <= 1'b0;
        repeat (RST_MIN - 2) @(posedge ref_clk);
        module_reset_n <= 1'b1;
        look(8);
        chk(8'(restore_defaults), 8'h00, "short pulse");
        bus_read(8'h02, d, 1'b0);
        chk(d, 8'(exp_ctrl), "ctrl kept");
        @(posedge ref_clk);
        module_reset_n <= 1'b0;
        look(RST_MIN + 8);
        chk(8'({restore_defaults, data_not_ready}), 8'h03, "long reset");
        @(posedge ref_clk);
        module_reset_n <= 1'b1;
        exp_ctrl = 0;
        exp_flags = 1;
        done_seq();
        chk_limit();
        bus_read(8'h02, d, 1'b0);
        chk(d, 8'(exp_ctrl), "ctrl default");
        @(posedge ref_clk);
        fault_event <= 1'b1;
        @(posedge ref_clk);
        fault_event <= 1'b0;
        exp_flags = 2;
        done_seq();
        stop_test();
    end
endmodule : mmpc_pin_ctrl_test

// file: verilog/mmpc_map.svh
// constants and field layout of the module management pin control block
`ifndef MMPC_MAP_SVH
`define MMPC_MAP_SVH

`define MMPC_CLK_PERIOD_NS 10
`define MMPC_RESET_MIN_NS 2000
`define MMPC_RESET_MIN_CYC ((`MMPC_RESET_MIN_NS + `MMPC_CLK_PERIOD_NS - 1) / `MMPC_CLK_PERIOD_NS)
`define MMPC_INIT_NS 1000
`define MMPC_INIT_CYC ((`MMPC_INIT_NS + `MMPC_CLK_PERIOD_NS - 1) / `MMPC_CLK_PERIOD_NS)
`define MMPC_CNT_W 16

`define MMPC_DEV_ADDR_DEF 7'h50

`define MMPC_ADDR_STATUS 8'h00
`define MMPC_ADDR_FLAGS 8'h01
`define MMPC_ADDR_CTRL 8'h02
`define MMPC_RD_UNMAPPED 8'h00

`define MMPC_ST_NOT_READY 0
`define MMPC_ST_PWR_LIMIT 1
`define MMPC_ST_LP_PIN 2
`define MMPC_ST_INT 3
`define MMPC_STATUS_RST 8'h00

`define MMPC_FL_RESET_DONE 0
`define MMPC_FL_FAULT 1
`define MMPC_FLAGS_RST 8'h00

`define MMPC_CT_SW_LP 0
`define MMPC_CT_OVR 1
`define MMPC_CTRL_RST 8'h00

`define MMPC_BIT_LAST 3'h7
`define MMPC_BIT_FIRST 3'h0

`endif

// file: verilog/mmpc_pin_ctrl.sv
// module management pins: select-gated two-wire slave, reset, low power, presence, interrupt
`timescale 1ns/1ns
`include "mmpc_map.svh"
module mmpc_pin_ctrl
    import mmpc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `MMPC_DEV_ADDR_DEF,
    parameter int CNT_W = `MMPC_CNT_W,
    parameter int RESET_MIN_CYC = `MMPC_RESET_MIN_CYC,
    parameter int INIT_CYC = `MMPC_INIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic fault_event,
    output logic module_present_n_out,
    output logic module_present_n_oe,
    output logic interrupt_out_n_out,
    output logic interrupt_out_n_oe,
    output logic power_limit,
    output logic restore_defaults,
    output logic data_not_ready
);
    localparam logic [CNT_W-1:0] RESET_MIN_V = CNT_W'(RESET_MIN_CYC);
    localparam logic [CNT_W-1:0] INIT_V = CNT_W'(INIT_CYC);

    // ---- reference clock side
    logic [3:0] ref_s;
    mmpc_state_type state_r;
    mmpc_state_type state_nxt;
    logic [CNT_W-1:0] rst_cnt_r;
    logic [CNT_W-1:0] rst_cnt_nxt;
    logic [CNT_W-1:0] init_cnt_r;
    logic [CNT_W-1:0] init_cnt_nxt;
    logic not_ready_r;
    logic not_ready_nxt;
    mmpc_byte_type flags_r;
    mmpc_byte_type flags_nxt;
    mmpc_byte_type flags_set;
    mmpc_byte_type flags_clr;
    mmpc_byte_type ctrl_r;
    mmpc_byte_type ctrl_nxt;
    mmpc_byte_type status_byte;
    logic wr_seen_r;
    logic rc_seen_r;
    logic power_limit_r;
    logic restore_r;
    logic int_oe_r;
    logic present_oe_r;
    logic present_out_r;
    logic int_out_r;

    // ---- link side
    logic [25:0] link_s;
    logic start_mark_r;
    logic start_seen_r;
    logic sda_pos_r;
    mmpc_tws_type ts_r;
    mmpc_tws_type ts_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    mmpc_byte_type shift_r;
    mmpc_byte_type shift_nxt;
    mmpc_byte_type tx_r;
    mmpc_byte_type tx_nxt;
    mmpc_byte_type snap_r;
    mmpc_byte_type snap_nxt;
    mmpc_byte_type ptr_r;
    mmpc_byte_type ptr_nxt;
    logic rw_r;
    logic rw_nxt;
    logic first_r;
    logic first_nxt;
    logic oe_r;
    logic oe_nxt;
    mmpc_byte_type wr_data_r;
    mmpc_byte_type wr_data_nxt;
    logic wr_tgl_r;
    logic wr_tgl_nxt;
    mmpc_byte_type rc_data_r;
    mmpc_byte_type rc_data_nxt;
    logic rc_tgl_r;
    logic rc_tgl_nxt;
    logic sda_out_r;

    // pins and link toggles into the reference domain
    mmpc_sync #(.WIDTH(4)) u_ref_sync (
        .clk(ref_clk),
        .din({module_reset_n, low_power_request, wr_tgl_r, rc_tgl_r}),
        .dout(ref_s)
    );

    wire reset_pin_low = ~ref_s[3];
    wire lp_pin = ref_s[2];
    // byte held stable on the link side until the next write, so it is safe to take here
    wire wr_evt = ref_s[1] ^ wr_seen_r;
    wire rc_evt = ref_s[0] ^ rc_seen_r;
    wire rst_at_min = (rst_cnt_r == RESET_MIN_V);
    wire reset_req = reset_pin_low & rst_at_min;
    wire init_end = (state_r == ST_INIT) && (init_cnt_r == INIT_V);
    wire init_done = init_end & ~reset_req;
    wire hold = (state_r == ST_HOLD) | reset_req;
    wire fault_set = fault_event & (state_r == ST_READY);

    // glitches on the reset pin shorter than the minimum never reach the counter limit
    assign rst_cnt_nxt = !reset_pin_low ? '0 : rst_at_min ? rst_cnt_r : rst_cnt_r + 1'b1;

    always_comb begin
        state_nxt = state_r;
        init_cnt_nxt = init_cnt_r;
        unique case (state_r)
            ST_INIT: begin
                if (init_end) begin
                    state_nxt = ST_READY;
                end else begin
                    init_cnt_nxt = init_cnt_r + 1'b1;
                end
            end
            ST_READY: begin
                state_nxt = ST_READY;
            end
            ST_HOLD: begin
                if (!reset_pin_low) begin
                    state_nxt = ST_INIT;
                    init_cnt_nxt = '0;
                end
            end
        endcase
        if (reset_req) begin
            state_nxt = ST_HOLD;
            init_cnt_nxt = '0;
        end
    end

    // not-ready stays set through the whole reset; status is meaningless until it drops
    assign not_ready_nxt = reset_req ? 1'b1 : init_done ? 1'b0 : not_ready_r;

    always_comb begin
        flags_set = `MMPC_FLAGS_RST;
        flags_set[`MMPC_FL_RESET_DONE] = init_done;
        flags_set[`MMPC_FL_FAULT] = fault_set;
    end

    // host clears only what it actually read; a set in the same cycle wins
    assign flags_clr = rc_evt ? rc_data_r : `MMPC_FLAGS_RST;
    assign flags_nxt = hold ? `MMPC_FLAGS_RST : (flags_r & ~flags_clr) | flags_set;
    assign ctrl_nxt = hold ? `MMPC_CTRL_RST : wr_evt ? wr_data_r : ctrl_r;

    always_comb begin
        status_byte = `MMPC_STATUS_RST;
        status_byte[`MMPC_ST_NOT_READY] = not_ready_r;
        status_byte[`MMPC_ST_PWR_LIMIT] = power_limit_r;
        status_byte[`MMPC_ST_LP_PIN] = lp_pin;
        status_byte[`MMPC_ST_INT] = int_oe_r;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= ST_INIT;
            rst_cnt_r <= '0;
            init_cnt_r <= '0;
            not_ready_r <= 1'b1;
            flags_r <= `MMPC_FLAGS_RST;
            ctrl_r <= `MMPC_CTRL_RST;
            wr_seen_r <= ref_s[1];
            rc_seen_r <= ref_s[0];
        end else begin
            state_r <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            init_cnt_r <= init_cnt_nxt;
            not_ready_r <= not_ready_nxt;
            flags_r <= flags_nxt;
            ctrl_r <= ctrl_nxt;
            wr_seen_r <= ref_s[1];
            rc_seen_r <= ref_s[0];
        end
    end

    // pin-facing flops; open-drain lines only ever drive low
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            power_limit_r <= 1'b1;
            restore_r <= 1'b1;
            int_oe_r <= 1'b0;
            present_oe_r <= 1'b1;
            present_out_r <= 1'b0;
            int_out_r <= 1'b0;
        end else begin
            power_limit_r <= ctrl_r[`MMPC_CT_OVR] ? ctrl_r[`MMPC_CT_SW_LP] : lp_pin;
            restore_r <= hold;
            int_oe_r <= |flags_nxt;
            present_oe_r <= 1'b1;
            present_out_r <= 1'b0;
            int_out_r <= 1'b0;
        end
    end

    // reference state into the link domain; each lane is an independent level
    mmpc_sync #(.WIDTH(26)) u_link_sync (
        .clk(scl),
        .din({rstn, module_select_n, ctrl_r, flags_r, status_byte}),
        .dout(link_s)
    );

    wire link_rstn = link_s[25];
    wire sel_n_s = link_s[24];
    wire [7:0] ctrl_s = link_s[23:16];
    wire [7:0] flags_s = link_s[15:8];
    wire [7:0] status_s = link_s[7:0];

    // start marker: sda falling while scl high; start hold time covers the next scl fall
    always_ff @(negedge sda_in or negedge rstn) begin
        if (!rstn) begin
            start_mark_r <= 1'b0;
        end else if (scl) begin
            start_mark_r <= ~start_mark_r;
        end
    end

    // sda is synchronous to scl by the bus protocol, sampled on the rising edge
    always_ff @(posedge scl) begin
        if (!link_rstn) begin
            sda_pos_r <= 1'b1;
        end else begin
            sda_pos_r <= sda_in;
        end
    end

    wire start_det = start_mark_r ^ start_seen_r;
    wire [7:0] rx_byte = {shift_r[6:0], sda_pos_r};
    wire bit_last = (bit_cnt_r == `MMPC_BIT_LAST);
    wire addr_hit = (rx_byte[7:1] == DEV_ADDR);
    wire [7:0] rd_byte = (ptr_r == `MMPC_ADDR_STATUS) ? status_s :
                         (ptr_r == `MMPC_ADDR_FLAGS) ? flags_s :
                         (ptr_r == `MMPC_ADDR_CTRL) ? ctrl_s : `MMPC_RD_UNMAPPED;

    always_comb begin
        ts_nxt = ts_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        snap_nxt = snap_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        first_nxt = first_r;
        oe_nxt = oe_r;
        wr_data_nxt = wr_data_r;
        wr_tgl_nxt = wr_tgl_r;
        rc_data_nxt = rc_data_r;
        rc_tgl_nxt = rc_tgl_r;
        unique case (ts_r)
            TS_IDLE: begin
                oe_nxt = 1'b0;
            end
            TS_ADDR: begin
                shift_nxt = rx_byte;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_last) begin
                    if (addr_hit) begin
                        ts_nxt = TS_ADDR_ACK;
                        oe_nxt = 1'b1;
                        rw_nxt = rx_byte[0];
                    end else begin
                        ts_nxt = TS_IDLE;
                    end
                end
            end
            TS_ADDR_ACK: begin
                bit_cnt_nxt = `MMPC_BIT_FIRST;
                if (rw_r) begin
                    ts_nxt = TS_RD;
                    tx_nxt = rd_byte;
                    snap_nxt = rd_byte;
                    oe_nxt = ~rd_byte[7];
                end else begin
                    ts_nxt = TS_WR;
                    oe_nxt = 1'b0;
                    first_nxt = 1'b1;
                end
            end
            TS_WR: begin
                shift_nxt = rx_byte;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_last) begin
                    ts_nxt = TS_WR_ACK;
                    oe_nxt = 1'b1;
                    first_nxt = 1'b0;
                    if (first_r) begin
                        ptr_nxt = rx_byte;
                    end else begin
                        ptr_nxt = ptr_r + 8'h01;
                        if (ptr_r == `MMPC_ADDR_CTRL) begin
                            wr_data_nxt = rx_byte;
                            wr_tgl_nxt = ~wr_tgl_r;
                        end
                    end
                end
            end
            TS_WR_ACK: begin
                ts_nxt = TS_WR;
                oe_nxt = 1'b0;
                bit_cnt_nxt = `MMPC_BIT_FIRST;
            end
            TS_RD: begin
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_last) begin
                    ts_nxt = TS_RD_ACK;
                    oe_nxt = 1'b0;
                    ptr_nxt = ptr_r + 8'h01;
                    if (ptr_r == `MMPC_ADDR_FLAGS) begin
                        rc_data_nxt = snap_r;
                        rc_tgl_nxt = ~rc_tgl_r;
                    end
                end else begin
                    tx_nxt = {tx_r[6:0], 1'b0};
                    oe_nxt = ~tx_r[6];
                end
            end
            TS_RD_ACK: begin
                if (!sda_pos_r) begin
                    ts_nxt = TS_RD;
                    tx_nxt = rd_byte;
                    snap_nxt = rd_byte;
                    oe_nxt = ~rd_byte[7];
                    bit_cnt_nxt = `MMPC_BIT_FIRST;
                end else begin
                    ts_nxt = TS_IDLE;
                end
            end
        endcase
        if (start_det) begin
            ts_nxt = TS_ADDR;
            bit_cnt_nxt = `MMPC_BIT_FIRST;
            oe_nxt = 1'b0;
        end
        // deselected: drop the transfer and never touch sda
        if (sel_n_s) begin
            ts_nxt = TS_IDLE;
            oe_nxt = 1'b0;
        end
    end

    // data and acks change on the falling edge, while scl is low
    always_ff @(negedge scl) begin
        if (!link_rstn) begin
            start_seen_r <= 1'b0;
            ts_r <= TS_IDLE;
            bit_cnt_r <= `MMPC_BIT_FIRST;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            snap_r <= 8'h00;
            ptr_r <= `MMPC_ADDR_STATUS;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            start_seen_r <= start_mark_r;
            ts_r <= ts_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            snap_r <= snap_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            first_r <= first_nxt;
            oe_r <= oe_nxt;
        end
    end

    always_ff @(negedge scl) begin
        if (!link_rstn) begin
            wr_data_r <= `MMPC_CTRL_RST;
            wr_tgl_r <= 1'b0;
            rc_data_r <= `MMPC_FLAGS_RST;
            rc_tgl_r <= 1'b0;
            sda_out_r <= 1'b0;
        end else begin
            wr_data_r <= wr_data_nxt;
            wr_tgl_r <= wr_tgl_nxt;
            rc_data_r <= rc_data_nxt;
            rc_tgl_r <= rc_tgl_nxt;
            sda_out_r <= 1'b0;
        end
    end

    // seven low-speed pins: select, scl, sda, reset, low power, presence, interrupt
    assign sda_out = sda_out_r;
    assign sda_oe = oe_r;
    assign module_present_n_out = present_out_r;
    assign module_present_n_oe = present_oe_r;
    assign interrupt_out_n_out = int_out_r;
    assign interrupt_out_n_oe = int_oe_r;
    assign power_limit = power_limit_r;
    assign restore_defaults = restore_r;
    assign data_not_ready = not_ready_r;

endmodule : mmpc_pin_ctrl

// file: verilog/mmpc_pkg.sv
// types shared by the module management pin control block
package mmpc_pkg;

    typedef logic [7:0] mmpc_byte_type;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_READY,
        ST_HOLD
    } mmpc_state_type;

    typedef enum logic [2:0] {
        TS_IDLE,
        TS_ADDR,
        TS_ADDR_ACK,
        TS_WR,
        TS_WR_ACK,
        TS_RD,
        TS_RD_ACK
    } mmpc_tws_type;

endpackage : mmpc_pkg

// file: verilog/mmpc_sync.sv
// two-flop level synchroniser, one bit per lane
`timescale 1ns/1ns
module mmpc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        meta_r <= din;
        dout <= meta_r;
    end
endmodule : mmpc_sync
